// file: common/csu_pkg.sv
// Constants and types for the compare and set-condition unit
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Register compare subtracts, sets flags, discards difference
// - Flags: equal, signed less, overflow, unsigned less
// - Negative flag is true signed order despite overflow
// - Immediate compare mirrors register compare
// - Status source subtracts carry flag instead
// - Bit test sets zero when AND is zero
// - Immediate selector zero tests any byte zero
// - Leading-zero count to destination, flags unchanged
// - Frame address from stack pointer, frame pointer, carry
// - Frame address is local-zero push address, flags kept
// - Shared set opcode decodes by selector and operand
// - Set-conditional writes destination, never flags
// - Selectors 4..15 write one or zero
//////////////////////////////////////////////////////////////////////////////
package csu_pkg;

  localparam int unsigned DATA_W = 32;

  // Operation classes presented by the decoder
  typedef enum logic [2:0] {
    CSU_REGISTER_COMPARE_OP  = 3'h0,
    CSU_IMMEDIATE_COMPARE_OP = 3'h1,
    CSU_BIT_TEST_REGISTER_OP = 3'h2,
    CSU_BIT_TEST_IMMEDIATE_OP = 3'h3,
    CSU_LEADING_ZERO_COUNT_OP = 3'h4,
    CSU_SHARED_SET_OPCODE    = 3'h5
  } csu_op_t;

  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_LAST_RESULT = 8'h04;
  localparam logic [7:0] REG_LAST_FLAGS  = 8'h08;

  // Control field and reset value
  localparam int unsigned  CTRL_ENABLE_BIT = 0;
  localparam logic [31:0]  CTRL_RESET      = 32'h0000_0001;

  // Flag positions in the flag vector
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;

  // Frame address fields
  localparam int unsigned FRAME_PTR_MSB = 31;
  localparam int unsigned FRAME_PTR_LSB = 25;
  localparam int unsigned STACK_HI_LSB  = 9;
  localparam int unsigned STACK_CARRY_B = 8;

  // Set-conditional selector values
  localparam logic [4:0] SEL_FRAME_ADDR = 5'h00;
  localparam logic [4:0] SEL_SET_ONE    = 5'h02;
  localparam logic [4:0] SEL_SET_ZERO   = 5'h03;
  localparam logic [4:0] SEL_SET_MONE   = 5'h12;
  localparam int unsigned SEL_MASK_BIT  = 4;

  // Selector of the any-byte-zero bit test
  localparam logic [4:0] SEL_BYTE_ZERO  = 5'h00;

endpackage : csu_pkg

// file: verilog/csu_unit.sv
// Compare, bit test, leading-zero, frame address and set-condition unit
`timescale 1ns/10ps
`default_nettype none

module csu_unit
(
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // Operation request
  input  wire logic                 op_valid,
  input  wire csu_pkg::csu_op_t     op_kind,
  input  wire logic [4:0]           op_sel,
  input  wire logic                 src_is_status,
  input  wire logic                 src_is_pc,
  input  wire logic [31:0]          dst_value,
  input  wire logic [31:0]          src_value,
  input  wire logic [31:0]          imm_value,
  // Core state
  input  wire logic [31:0]          status_word,
  input  wire logic [31:0]          stack_pointer,
  input  wire logic [3:0]           flags_in,
  // Results
  output logic                      dst_we,
  output logic [31:0]               dst_data,
  output logic                      flags_we,
  output logic [3:0]                flags_out,
  output logic                      fetch_req,
  output logic                      reserved_op,
  // Register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata
);

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [5:0] lead_zeros(input logic [31:0] v);
    logic [5:0] cnt;
    logic       seen;
    cnt  = 6'd0;
    seen = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      if (v[i])
        seen = 1'b1;
      else if (!seen)
        cnt = cnt + 6'd1;
    end
    return cnt;
  endfunction : lead_zeros

  // Shared condition table; low four selector bits pick the test
  function automatic logic cond_true(input logic [3:0] s,
                                     input logic [3:0] f);
    logic c;
    logic z;
    logic n;
    logic v;
    c = f[csu_pkg::FLAG_C];
    z = f[csu_pkg::FLAG_Z];
    n = f[csu_pkg::FLAG_N];
    v = f[csu_pkg::FLAG_V];
    case (s)
      4'h4:    cond_true = n | z;
      4'h5:    cond_true = ~n & ~z;
      4'h6:    cond_true = n;
      4'h7:    cond_true = ~n;
      4'h8:    cond_true = c | z;
      4'h9:    cond_true = ~c & ~z;
      4'hA:    cond_true = c;
      4'hB:    cond_true = ~c;
      4'hC:    cond_true = z;
      4'hD:    cond_true = ~z;
      4'hE:    cond_true = v;
      4'hF:    cond_true = ~v;
      default: cond_true = 1'b0;
    endcase
  endfunction : cond_true

  //////////////////////////////////////////////////////////////////////////
  // Datapath

  logic [31:0] ctrl_ff;
  logic        run;
  logic [31:0] cmp_rhs;
  logic [32:0] diff;
  logic        ovf;
  logic [31:0] and_res;
  logic        byte_zero;
  logic [31:0] frame_base;
  logic [31:0] frame_addr;
  logic        frame_carry;
  logic        cond;
  logic [31:0] true_val;

  assign run = op_valid & ctrl_ff[csu_pkg::CTRL_ENABLE_BIT];

  always_comb
  begin
    // Status operand means the carry flag, zero-extended
    if (op_kind == csu_pkg::CSU_IMMEDIATE_COMPARE_OP)
      cmp_rhs = imm_value;
    else if (src_is_status)
      cmp_rhs = {31'h0, flags_in[csu_pkg::FLAG_C]};
    else
      cmp_rhs = src_value;
    diff = {1'b0, dst_value} - {1'b0, cmp_rhs};
    // Overflow when operand signs differ and result sign follows rhs
    ovf  = (dst_value[31] ^ cmp_rhs[31]) & (diff[31] ^ dst_value[31]);
  end

  always_comb
  begin
    and_res   = dst_value &
                ((op_kind == csu_pkg::CSU_BIT_TEST_IMMEDIATE_OP) ?
                 imm_value : src_value);
    byte_zero = (dst_value[31:24] == 8'h00) |
                (dst_value[23:16] == 8'h00) |
                (dst_value[15:8]  == 8'h00) |
                (dst_value[7:0]   == 8'h00);
  end

  always_comb
  begin
    // Carry into bit 9 when the frame index wrapped below the stack top
    frame_carry = stack_pointer[csu_pkg::STACK_CARRY_B] &
                  ~status_word[csu_pkg::FRAME_PTR_MSB];
    frame_base  = {stack_pointer[31:csu_pkg::STACK_HI_LSB],
                   status_word[csu_pkg::FRAME_PTR_MSB:csu_pkg::FRAME_PTR_LSB],
                   2'b00};
    frame_addr  = frame_base +
                  {22'h0, frame_carry, 9'h000};
  end

  always_comb
  begin
    cond     = cond_true(op_sel[3:0], flags_in);
    true_val = op_sel[csu_pkg::SEL_MASK_BIT] ?
               32'hFFFF_FFFF : 32'h0000_0001;
  end

  //////////////////////////////////////////////////////////////////////////
  // Result registers

  logic        dst_we_ff;
  logic [31:0] dst_data_ff;
  logic        flags_we_ff;
  logic [3:0]  flags_out_ff;
  logic        fetch_req_ff;
  logic        reserved_op_ff;
  logic        nxt_dst_we;
  logic [31:0] nxt_dst_data;
  logic        nxt_flags_we;
  logic [3:0]  nxt_flags_out;
  logic        nxt_fetch_req;
  logic        nxt_reserved_op;

  always_comb
  begin
    nxt_dst_we      = 1'b0;
    nxt_dst_data    = dst_data_ff;
    nxt_flags_we    = 1'b0;
    nxt_flags_out   = flags_out_ff;
    nxt_fetch_req   = 1'b0;
    nxt_reserved_op = 1'b0;
    if (run)
    begin
      case (op_kind)
        csu_pkg::CSU_REGISTER_COMPARE_OP,
        csu_pkg::CSU_IMMEDIATE_COMPARE_OP:
        begin
          // Difference is never written back
          nxt_flags_we                   = 1'b1;
          nxt_flags_out[csu_pkg::FLAG_Z] = (diff[31:0] == 32'h0);
          nxt_flags_out[csu_pkg::FLAG_N] = diff[31] ^ ovf;
          nxt_flags_out[csu_pkg::FLAG_V] = ovf;
          nxt_flags_out[csu_pkg::FLAG_C] = diff[32];
        end
        csu_pkg::CSU_BIT_TEST_REGISTER_OP,
        csu_pkg::CSU_BIT_TEST_IMMEDIATE_OP:
        begin
          nxt_flags_we  = 1'b1;
          nxt_flags_out = flags_in;
          if (op_kind == csu_pkg::CSU_BIT_TEST_IMMEDIATE_OP &&
              op_sel == csu_pkg::SEL_BYTE_ZERO)
            nxt_flags_out[csu_pkg::FLAG_Z] = byte_zero;
          else
            nxt_flags_out[csu_pkg::FLAG_Z] = (and_res == 32'h0);
        end
        csu_pkg::CSU_LEADING_ZERO_COUNT_OP:
        begin
          // Flags untouched: flags_we stays low
          nxt_dst_we   = 1'b1;
          nxt_dst_data = {26'h0, lead_zeros(src_value)};
        end
        csu_pkg::CSU_SHARED_SET_OPCODE:
        begin
          if (src_is_status)
            nxt_fetch_req = 1'b1;
          else if (src_is_pc)
            nxt_reserved_op = 1'b1;
          else if (op_sel == csu_pkg::SEL_FRAME_ADDR)
          begin
            nxt_dst_we   = 1'b1;
            nxt_dst_data = frame_addr;
          end
          else
          begin
            // Never touches flags on any selector
            case (op_sel)
              csu_pkg::SEL_SET_ONE:
              begin
                nxt_dst_we   = 1'b1;
                nxt_dst_data = 32'h0000_0001;
              end
              csu_pkg::SEL_SET_ZERO:
              begin
                nxt_dst_we   = 1'b1;
                nxt_dst_data = 32'h0000_0000;
              end
              csu_pkg::SEL_SET_MONE:
              begin
                nxt_dst_we   = 1'b1;
                nxt_dst_data = 32'hFFFF_FFFF;
              end
              5'h01, 5'h10, 5'h11, 5'h13:
                nxt_reserved_op = 1'b1;
              default:
              begin
                nxt_dst_we   = 1'b1;
                nxt_dst_data = cond ? true_val : 32'h0000_0000;
              end
            endcase
          end
        end
        default:
          nxt_reserved_op = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      dst_we_ff      <= 1'b0;
      dst_data_ff    <= 32'h0000_0000;
      flags_we_ff    <= 1'b0;
      flags_out_ff   <= 4'h0;
      fetch_req_ff   <= 1'b0;
      reserved_op_ff <= 1'b0;
    end
    else
    begin
      dst_we_ff      <= nxt_dst_we;
      dst_data_ff    <= nxt_dst_data;
      flags_we_ff    <= nxt_flags_we;
      flags_out_ff   <= nxt_flags_out;
      fetch_req_ff   <= nxt_fetch_req;
      reserved_op_ff <= nxt_reserved_op;
    end
  end

  assign dst_we      = dst_we_ff;
  assign dst_data    = dst_data_ff;
  assign flags_we    = flags_we_ff;
  assign flags_out   = flags_out_ff;
  assign fetch_req   = fetch_req_ff;
  assign reserved_op = reserved_op_ff;

  //////////////////////////////////////////////////////////////////////////
  // Register port

  logic [31:0] nxt_ctrl;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  always_comb
  begin
    nxt_ctrl  = ctrl_ff;
    nxt_rdata = 32'h0000_0000;
    if (reg_wr && reg_addr == csu_pkg::REG_CTRL)
      nxt_ctrl = {31'h0, reg_wdata[csu_pkg::CTRL_ENABLE_BIT]};
    if (reg_rd)
    begin
      // Unmapped addresses read as zero
      case (reg_addr)
        csu_pkg::REG_CTRL:        nxt_rdata = ctrl_ff;
        csu_pkg::REG_LAST_RESULT: nxt_rdata = dst_data_ff;
        csu_pkg::REG_LAST_FLAGS:  nxt_rdata = {28'h0, flags_out_ff};
        default:                  nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ctrl_ff  <= csu_pkg::CTRL_RESET;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      ctrl_ff  <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule : csu_unit

`default_nettype wire

// file: verification/csu_unit_monitor.sv
// Assertion checker for the compare and set-condition unit
`timescale 1ns/10ps
`default_nettype none
module csu_unit_monitor
(
  // Clock and reset
  input wire logic             clock,
  input wire logic             rst_n,
  // Request
  input wire logic             op_valid,
  input wire csu_pkg::csu_op_t op_kind,
  input wire logic [4:0]       op_sel,
  input wire logic             src_is_status,
  input wire logic             src_is_pc,
  input wire logic [31:0]      dst_value,
  input wire logic [31:0]      src_value,
  input wire logic [31:0]      imm_value,
  input wire logic [31:0]      status_word,
  input wire logic [31:0]      stack_pointer,
  input wire logic [3:0]       flags_in,
  // Results
  input wire logic             dst_we,
  input wire logic [31:0]      dst_data,
  input wire logic             flags_we,
  input wire logic [3:0]       flags_out,
  input wire logic             fetch_req,
  // Register port
  input wire logic [7:0]       reg_addr,
  input wire logic [31:0]      reg_wdata,
  input wire logic             reg_wr
);
  logic en_ff;
  logic nxt_en;
  logic go;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Ops are refused while disabled, so mirror the enable
  always_comb
  begin
    nxt_en = en_ff;
    if (!rst_n)
      nxt_en = 1'b1;
    else if (reg_wr && reg_addr == csu_pkg::REG_CTRL)
      nxt_en = reg_wdata[0];
  end
  always_ff @(posedge clock) en_ff <= nxt_en;
  assign go = op_valid && en_ff;
  function automatic logic [3:0] cmpf(logic [31:0] a, logic [31:0] b);
    logic [31:0] d;
    d = a - b;
    return {a[31] != b[31] && d[31] != a[31], $signed(a) < $signed(b),
            a == b, a < b};
  endfunction : cmpf
  function automatic logic [31:0] fa(logic [31:0] p, logic [31:0] r);
    return {p[31:9], r[31:25], 2'b00} + {22'h0, p[8] & ~r[31], 9'h000};
  endfunction : fa
  ////////////////////////////////////////
  reg_cmp_a:
    assert property (go && op_kind == 3'h0 && !src_is_status |=> flags_we
      && !dst_we && flags_out == cmpf($past(dst_value), $past(src_value)))
    else $error("register compare flags wrong");
  imm_cmp_a:
    assert property (go && op_kind == 3'h1 |=> flags_we
      && flags_out == cmpf($past(dst_value), $past(imm_value)))
    else $error("immediate compare flags wrong");
  status_cmp_a:
    assert property (go && op_kind == 3'h0 && src_is_status |=> flags_out
      == cmpf($past(dst_value), 32'($past(flags_in) & 4'h1)))
    else $error("carry compare flags wrong");
  bit_test_a:
    assert property (go && op_kind == 3'h2 |=> flags_we && flags_out ==
      ($past(flags_in) & 4'hd | {2'h0,
      ($past(dst_value) & $past(src_value)) == 32'h0, 1'b0}))
    else $error("bit test flags wrong");
  lzc_flags_a:
    assert property (go && op_kind == 3'h4 |=> dst_we && !flags_we)
    else $error("leading zero count touched flags");
  set_flags_a:
    assert property (go && op_kind == 3'h5 |=> !flags_we)
    else $error("set group touched flags");
  fetch_route_a:
    assert property (go && op_kind == 3'h5 && src_is_status
      |=> fetch_req && !dst_we)
    else $error("status operand not routed to fetch");
  frame_addr_a:
    assert property (go && op_kind == 3'h5 && op_sel == 5'h00
      && !src_is_status && !src_is_pc |=> dst_we && dst_data
      == fa($past(stack_pointer), $past(status_word)))
    else $error("frame address wrong");
endmodule : csu_unit_monitor
bind csu_unit csu_unit_monitor u_mon (.clock, .rst_n, .op_valid, .op_kind,
  .op_sel, .src_is_status, .src_is_pc, .dst_value, .src_value, .imm_value,
  .status_word, .stack_pointer, .flags_in, .dst_we, .dst_data, .flags_we,
  .flags_out, .fetch_req, .reg_addr, .reg_wdata, .reg_wr);
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking testbench for the compare and set-condition unit
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic             clock, rst_n, op_valid, src_is_status, src_is_pc;
  logic             reg_wr, reg_rd, dst_we, flags_we, fetch_req, reserved_op;
  csu_pkg::csu_op_t op_kind;
  logic [4:0]       op_sel;
  logic [3:0]       flags_in, flags_out;
  logic [7:0]       reg_addr;
  logic [31:0]      dst_value, src_value, imm_value, status_word;
  logic [31:0]      stack_pointer, reg_wdata, reg_rdata, dst_data;
  int               n_fail, n_tests;
  csu_unit dut (.clock, .rst_n, .op_valid, .op_kind, .op_sel, .src_is_status,
    .src_is_pc, .dst_value, .src_value, .imm_value, .status_word,
    .stack_pointer, .flags_in, .dst_we, .dst_data, .flags_we, .flags_out,
    .fetch_req, .reserved_op, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata);
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [3:0] ef(logic [31:0] a, logic [31:0] b);
    logic [31:0] d;
    d = a - b;
    return {a[31] ^ b[31] && a[31] ^ d[31], $signed(a) < $signed(b),
            a == b, a < b};
  endfunction : ef
  // Unused operand gets the inverse so a wrong pick shows
  task automatic op(input logic [2:0] k, input logic [4:0] s,
                    input logic [31:0] d, input logic [31:0] r);
    @(posedge clock);
    op_valid <= 1'b1;
    op_kind <= csu_pkg::csu_op_t'(k);
    op_sel <= s;
    dst_value <= d;
    src_value <= k[0] ? ~r : r;
    imm_value <= k[0] ? r : ~r;
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
  endtask : op
  task automatic reg_op(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
    @(posedge clock);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    if (!w)
      chk(reg_rdata, d);
  endtask : reg_op
  task automatic t_regs();
    reg_op(1'b0, csu_pkg::REG_CTRL, csu_pkg::CTRL_RESET);
    op(3'h4, 5'h00, 32'h0, 32'h0000_00ff);
    op(3'h0, 5'h00, 32'h0000_0005, 32'h0000_0007);
    reg_op(1'b1, csu_pkg::REG_LAST_RESULT, 32'h0);
    reg_op(1'b0, csu_pkg::REG_LAST_RESULT, 32'h0000_0018);
    reg_op(1'b0, csu_pkg::REG_LAST_FLAGS, 32'h0000_0005);
    reg_op(1'b0, 8'h0c, 32'h0);
    reg_op(1'b1, csu_pkg::REG_CTRL, 32'h0);
    op(3'h0, 5'h00, 32'h1, 32'h1);
    chk({30'h0, dst_we, flags_we}, 32'h0);
    chk({28'h0, flags_out}, 32'h0000_0005);
    reg_op(1'b1, csu_pkg::REG_CTRL, 32'h1);
  endtask : t_regs
  task automatic t_compare();
    logic [31:0] a[5] = '{32'h0000_0005, 32'h8000_0000, 32'h7fff_ffff,
                          32'h1234_5678, 32'h0000_0000};
    logic [31:0] b[5] = '{32'h0000_0007, 32'h0000_0001, 32'hffff_ffff,
                          32'h1234_5678, 32'h8000_0000};
    for (int k = 0; k < 2; k++)
      for (int i = 0; i < 5; i++)
      begin
        op(k[2:0], 5'h00, a[i], b[i]);
        chk({26'h0, dst_we, flags_we, flags_out}, {28'h1, ef(a[i], b[i])});
      end
    src_is_status <= 1'b1;
    for (int c = 0; c < 2; c++)
    begin
      flags_in <= {3'h0, c[0]};
      op(3'h0, 5'h00, 32'h0, 32'h0000_1234);
      chk({28'h0, flags_out}, {28'h0, ef(32'h0, 32'(c[0]))});
    end
    src_is_status <= 1'b0;
  endtask : t_compare
  task automatic t_bits();
    flags_in <= 4'hd;
    op(3'h2, 5'h01, 32'hf0f0_0000, 32'h0f0f_ffff);
    chk({28'h0, flags_out}, 32'hf);
    op(3'h3, 5'h01, 32'h0000_0001, 32'h0000_0001);
    chk({28'h0, flags_out}, 32'hd);
    op(3'h3, 5'h00, 32'h1122_0033, 32'hffff_ffff);
    chk({28'h0, flags_out}, 32'hf);
    op(3'h3, 5'h00, 32'h1122_3344, 32'h0);
    chk({28'h0, flags_out}, 32'hd);
  endtask : t_bits
  task automatic t_lzc();
    logic [31:0] v[4] = '{32'h0, 32'h1, 32'h8000_0000, 32'h0001_ffff};
    logic [31:0] e[4] = '{32'h20, 32'h1f, 32'h0, 32'hf};
    for (int i = 0; i < 4; i++)
    begin
      op(3'h4, 5'h00, 32'h5555_5555, v[i]);
      chk(dst_data, e[i]);
      chk({30'h0, dst_we, flags_we}, 32'h2);
    end
  endtask : t_lzc
  task automatic t_set();
    logic [31:0] e;
    logic        c;
    for (int f = 0; f < 16; f++)
      for (int s = 1; s < 32; s++)
      begin
        flags_in <= f[3:0];
        op(3'h5, s[4:0], 32'h5a5a_5a5a, 32'h0);
        case (s[3:1])
          3'h2: c = f[2] | f[1];
          3'h3: c = f[2];
          3'h4: c = f[0] | f[1];
          3'h5: c = f[0];
          3'h6: c = f[1];
          default: c = f[3];
        endcase
        e = (s == 2 || s == 18) ? 32'h1 : s == 3 ? 32'h0 : 32'(c ^ s[0]);
        e = s[4] ? -e : e;
        if (s inside {1, 16, 17, 19})
          chk({29'h0, reserved_op, dst_we, flags_we}, 32'h4);
        else
        begin
          chk({29'h0, reserved_op, flags_we, dst_we}, 32'h1);
          chk(dst_data, e);
        end
      end
  endtask : t_set
  task automatic t_frame();
    logic [31:0] p[3] = '{32'h1234_5100, 32'h1234_5100, 32'hffff_fe00};
    logic [31:0] r[3] = '{32'h0200_0000, 32'h8200_0000, 32'h7e00_0000};
    logic [31:0] e[3] = '{32'h1234_5204, 32'h1234_5104, 32'hffff_fefc};
    for (int i = 0; i < 3; i++)
    begin
      stack_pointer <= p[i];
      status_word <= r[i];
      op(3'h5, 5'h00, 32'h0, 32'h0);
      chk(dst_data, e[i]);
    end
    src_is_status <= 1'b1;
    op(3'h5, 5'h00, 32'h0, 32'h0);
    chk({28'h0, fetch_req, reserved_op, dst_we, flags_we}, 32'h8);
    src_is_status <= 1'b0;
    src_is_pc <= 1'b1;
    op(3'h5, 5'h04, 32'h0, 32'h0);
    chk({28'h0, fetch_req, reserved_op, dst_we, flags_we}, 32'h4);
    src_is_pc <= 1'b0;
    op(3'h6, 5'h00, 32'h0, 32'h0);
    chk({28'h0, fetch_req, reserved_op, dst_we, flags_we}, 32'h4);
  endtask : t_frame
  task automatic results();
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  initial
  begin
    {rst_n, op_valid, src_is_status, src_is_pc, reg_wr, reg_rd} = '0;
    {op_sel, flags_in, reg_addr, dst_value, src_value} = '0;
    {imm_value, status_word, stack_pointer, reg_wdata} = '0;
    op_kind = csu_pkg::CSU_REGISTER_COMPARE_OP;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_compare();
    t_bits();
    t_lzc();
    t_set();
    t_frame();
    results();
  end
  // Run needs about 1100 cycles; allow ten times that
  initial
  begin
    #88000;
    n_fail++;
    results();
  end
endmodule : tb_top
`default_nettype wire
